// ---- bcc_consts.svh ----
// Constants for the bus cycle controller: bit positions, delays, resets.
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH

// Number of pin inputs that pass the two-flop synchroniser.
`define BCC_PIN_W 8
// Bit positions of the pin inputs inside the synchroniser vector.
`define BCC_PIN_STAT_HI 0
`define BCC_PIN_STAT_LO 1
`define BCC_PIN_MEM_IO 2
`define BCC_PIN_STRAP 3
`define BCC_PIN_BUS_SEL 4
`define BCC_PIN_HOLD_OFF 5
`define BCC_PIN_EN_GRANT 6
`define BCC_PIN_READY_N 7
// Synchroniser reset levels: every pin high except the timing strap.
// A strap that read high before its true level arrived would float the
// commands of a fast-mode controller for two clocks after reset.
`define BCC_PIN_RST 8'hf7

// Width of the command vector and the index of each command.
`define BCC_CMD_W 5
`define BCC_CMD_IRQ_ACK 0
`define BCC_CMD_IO_RD 1
`define BCC_CMD_IO_WR 2
`define BCC_CMD_MEM_RD 3
`define BCC_CMD_MEM_WR 4

// Extra clocks of command delay in system-bus timing.
`define BCC_RD_CMD_DELAY 2'd1
`define BCC_WR_CMD_DELAY 2'd2
// Clock edges from a bus grant to commands going active.
`define BCC_GRANT_EDGES 2'd3

// Reset values of the outputs.
`define BCC_RST_CMD_N 5'h1f
`define BCC_RST_CMD_OE 1'b1
`define BCC_RST_ALE 1'b0
`define BCC_RST_MCE 1'b0
`define BCC_RST_DEN 1'b0
`define BCC_RST_DIR 1'b1

`endif

// ---- bcc_pkg.sv ----
// Types shared by the bus cycle controller modules.
package bcc_pkg;

  // Bus states; Gray coded along idle, status, first and second command half.
  typedef enum logic [1:0] {
    BCC_IDLE = 2'h0,
    BCC_STAT = 2'h1,
    BCC_CMD1 = 2'h3,
    BCC_CMD2 = 2'h2
  } bcc_state_e;

  // Cycle type, coded as {mem_io_sel, status_hi_n, status_lo_n}.
  typedef enum logic [2:0] {
    BCC_CYC_IRQ_ACK = 3'h0,
    BCC_CYC_IO_RD = 3'h1,
    BCC_CYC_IO_WR = 3'h2,
    BCC_CYC_IDLE0 = 3'h3,
    BCC_CYC_HALT = 3'h4,
    BCC_CYC_MEM_RD = 3'h5,
    BCC_CYC_MEM_WR = 3'h6,
    BCC_CYC_IDLE1 = 3'h7
  } bcc_cycle_e;

endpackage

// ---- bcc_pins_if.sv ----
// Interface carrying raw pins into the synchroniser and clean levels out.
`timescale 1ns/1ps
`include "bcc_consts.svh"

interface bcc_pins_if;
  // Raw pin levels, straight from outside the clock domain.
  logic [`BCC_PIN_W-1:0] raw;
  // Levels after two flip-flops, safe for the control logic.
  logic [`BCC_PIN_W-1:0] clean;

  // The synchroniser takes raw levels and returns clean ones.
  modport sync (input raw, output clean);
  // The controller fills raw levels and reads clean ones.
  modport ctrl (output raw, input clean);
endinterface

// ---- bcc_pin_sync.sv ----
// Two-flop synchroniser bank for the controller's pin inputs.
`timescale 1ns/1ps
`include "bcc_consts.svh"

module bcc_pin_sync
  import bcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  bcc_pins_if.sync pins
);

  // First stage; read only by the second stage of the same bit.
  logic [`BCC_PIN_W-1:0] meta_reg;
  // Second stage; this is what the controller sees.
  logic [`BCC_PIN_W-1:0] clean_reg;
  // Level that each stage takes while reset is held.
  localparam logic [`BCC_PIN_W-1:0] rst_lvl = `BCC_PIN_RST;

  // One synchroniser per pin, so a late pin never skews another.
  genvar gi;
  generate
    for (gi = 0; gi < `BCC_PIN_W; gi = gi + 1) begin : g_bit
      // Reset leaves status idle, ready high and the strap in fast timing.
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          meta_reg[gi] <= rst_lvl[gi];
          clean_reg[gi] <= rst_lvl[gi];
        end else begin
          meta_reg[gi] <= pins.raw[gi];
          clean_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign pins.clean = clean_reg;

endmodule

// ---- bcc_cycle_ctrl.sv ----
// Bus cycle controller: decodes cycle status into commands and strobes.
//
// Behaviour
// RULE1 - Sample status each edge; low starts cycle.
// RULE2 - Three bus states, each two clocks.
// RULE3 - Idle may repeat while no cycle runs.
// RULE4 - Status then command; wait states repeat command.
// RULE5 - Ready high at command end repeats state.
// RULE6 - Ready low ends cycle; may restart directly.
// RULE7 - Decode select and status into cycle type.
// RULE8 - Direction low for reads; strobes skip idle/halt.
// RULE9 - Reads share timing; cascade only on acknowledge.
// RULE10 - Writes share timing, differ only in command.
// RULE11 - Halt drives nothing and ignores control inputs.
// RULE12 - Drop data enable before changing direction.
// RULE13 - Back-to-back cycles keep output timing unchanged.
// RULE14 - Fast back-to-back writes keep enable, direction high.
// RULE15 - System-bus mode delays read, write, enable.
// RULE16 - System-bus mode needs one wait state.
// RULE17 - System-bus data enable drops between cycles.
// RULE18 - Address strobe in second status half.
// RULE19 - Cascade strobe one clock longer than address.
// RULE20 - Master asserts status only in phase one.
// RULE21 - Master changes address only late command.
// RULE22 - Latch bus-select enable at cycle start.
// RULE23 - System-bus drives nothing without arbiter grant.
// RULE24 - Deselected cycle: no command, ignores inputs.
// RULE25 - Grant loss floats; grant enables after three.
// RULE26 - Fast mode enable gates commands and enable.
// RULE27 - Hold-off sampled from status end until low.
// RULE28 - Reset rests idle with outputs inactive.
`timescale 1ns/1ps
`include "bcc_consts.svh"

module bcc_cycle_ctrl
  import bcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cycle_status_hi_n_i,
  input wire logic cycle_status_lo_n_i,
  input wire logic mem_io_sel_i,
  input wire logic sysbus_timing_strap_i,
  input wire logic bus_select_latched_i,
  input wire logic command_hold_off_i,
  input wire logic enable_or_grant_i,
  input wire logic ready_n_i,
  output logic irq_ack_cmd_n_o,
  output logic io_read_cmd_n_o,
  output logic io_write_cmd_n_o,
  output logic mem_read_cmd_n_o,
  output logic mem_write_cmd_n_o,
  output logic cmd_oe_o,
  output logic addr_latch_strobe_o,
  output logic cascade_enable_strobe_o,
  output logic transceiver_enable_o,
  output logic transfer_direction_o
);

  // True for the three read-type cycles, which share all their timing.
  function automatic logic is_read(input bcc_cycle_e c);
    is_read = (c == BCC_CYC_IRQ_ACK) || (c == BCC_CYC_IO_RD) ||
              (c == BCC_CYC_MEM_RD);
  endfunction

  // True for the two write cycles, which share all their timing.
  function automatic logic is_write(input bcc_cycle_e c);
    is_write = (c == BCC_CYC_IO_WR) || (c == BCC_CYC_MEM_WR);
  endfunction

  // Pins go through the synchroniser before any logic looks at them.
  bcc_pins_if pins ();

  assign pins.raw[`BCC_PIN_STAT_HI] = cycle_status_hi_n_i;
  assign pins.raw[`BCC_PIN_STAT_LO] = cycle_status_lo_n_i;
  assign pins.raw[`BCC_PIN_MEM_IO] = mem_io_sel_i;
  assign pins.raw[`BCC_PIN_STRAP] = sysbus_timing_strap_i;
  assign pins.raw[`BCC_PIN_BUS_SEL] = bus_select_latched_i;
  assign pins.raw[`BCC_PIN_HOLD_OFF] = command_hold_off_i;
  assign pins.raw[`BCC_PIN_EN_GRANT] = enable_or_grant_i;
  assign pins.raw[`BCC_PIN_READY_N] = ready_n_i;

  bcc_pin_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pins(pins)
  );

  // Clean copies of each pin, named by what they mean here.
  logic stat_hi_n; // Status high bit, active low.
  logic stat_lo_n; // Status low bit, active low.
  logic mem_sel; // High for memory space, low for I/O space.
  logic sysbus; // Strap: high selects system-bus timing.
  logic bus_sel; // Bus-select enable, active high.
  logic hold_off; // Command hold-off, active high.
  logic en_grant; // Enable (fast) or active-low grant (system bus).
  logic ready_n; // Cycle end request, active low.

  assign stat_hi_n = pins.clean[`BCC_PIN_STAT_HI];
  assign stat_lo_n = pins.clean[`BCC_PIN_STAT_LO];
  assign mem_sel = pins.clean[`BCC_PIN_MEM_IO];
  assign sysbus = pins.clean[`BCC_PIN_STRAP];
  assign bus_sel = pins.clean[`BCC_PIN_BUS_SEL];
  assign hold_off = pins.clean[`BCC_PIN_HOLD_OFF];
  assign en_grant = pins.clean[`BCC_PIN_EN_GRANT];
  assign ready_n = pins.clean[`BCC_PIN_READY_N];

  // Control state.
  bcc_state_e state_reg; // Current bus state.
  bcc_state_e state_next; // Bus state for the next clock.
  bcc_cycle_e cycle_reg; // Type of the running cycle.
  logic sel_reg; // Bus-select enable caught at cycle start.
  logic [1:0] cnt_reg; // Clocks spent in command, saturating.
  logic [1:0] cnt_next; // Command clock count for the next clock.
  logic hold_ok_reg; // Hold-off has been seen low in this cycle.
  logic hold_ok_now; // Hold-off released as of this edge.
  logic [1:0] grant_cnt_reg; // Edges since the grant went low.
  logic [1:0] grant_cnt_next; // Grant edge count for the next clock.

  // Output flip-flops and their next values.
  logic [`BCC_CMD_W-1:0] cmd_n_reg;
  logic [`BCC_CMD_W-1:0] cmd_n_next;
  logic cmd_oe_reg;
  logic ale_reg;
  logic ale_next;
  logic mce_reg;
  logic mce_next;
  logic den_reg;
  logic den_next;
  logic dir_reg;
  logic dir_next;

  // Helper terms of the next-state logic.
  logic start; // Status sampled active at this edge.
  bcc_cycle_e dec_cycle; // Cycle type decoded from the pins.
  logic starting; // A status state begins at this edge.
  logic in_cmd_next; // The next clock lies in a command state.
  logic [1:0] need; // Command delay due to the timing mode.
  logic cmd_en; // Enable or grant lets commands go active.
  logic drv_en; // Enable or grant lets data enable go active.
  logic want_read_dir; // The next clock wants the read direction.
  logic want_den; // The next clock wants data enable active.

  // Any low status bit starts a cycle; idle codes never start one.
  assign start = !stat_hi_n || !stat_lo_n; // RULE1
  assign dec_cycle = bcc_cycle_e'({mem_sel, stat_hi_n, stat_lo_n}); // RULE7

  // Bus state sequencing.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      // Idle repeats for as long as no status is seen.
      BCC_IDLE: begin
        state_next = start ? BCC_STAT : BCC_IDLE; // RULE3
      end
      // Halt and deselected cycles fall back to idle.
      BCC_STAT: begin
        if ((cycle_reg == BCC_CYC_HALT) || !sel_reg) begin // RULE11 RULE24
          state_next = BCC_IDLE;
        end else begin
          state_next = BCC_CMD1; // RULE4
        end
      end
      // First half of a command state.
      BCC_CMD1: begin
        state_next = BCC_CMD2; // RULE2
      end
      // Ready is sampled at the end of every command state.
      BCC_CMD2: begin
        if (ready_n) begin
          state_next = BCC_CMD1; // RULE5
        end else if (start) begin
          state_next = BCC_STAT; // RULE6
        end else begin
          state_next = BCC_IDLE;
        end
      end
      default: begin
        state_next = BCC_IDLE;
      end
    endcase
  end

  // The status state lasts one clock here because the first status
  // half is the clock in which the pins were sampled low.
  assign starting = (state_next == BCC_STAT);
  assign in_cmd_next = (state_next == BCC_CMD1) ||
                       (state_next == BCC_CMD2);

  // Bus state register.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= BCC_IDLE; // RULE28
    end else begin
      state_reg <= state_next;
    end
  end

  // Cycle type and bus select are caught as the cycle starts, so an
  // address decoder may move on while the cycle runs.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cycle_reg <= BCC_CYC_IDLE1;
      sel_reg <= 1'b0;
    end else if (starting) begin
      cycle_reg <= dec_cycle;
      sel_reg <= bus_sel; // RULE22
    end
  end

  // Clocks into the command phase; drives the system-bus delays.
  assign cnt_next = (state_reg == BCC_STAT) ? 2'd0 :
                    ((cnt_reg == 2'd3) ? cnt_reg : cnt_reg + 2'd1);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 2'd0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Hold-off is first looked at on the edge closing the status state,
  // then on each edge until it is seen low.
  assign hold_ok_now = (state_reg == BCC_STAT) ? !hold_off : // RULE27
                       (hold_ok_reg || !hold_off);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hold_ok_reg <= 1'b0;
    end else if (!in_cmd_next) begin
      hold_ok_reg <= 1'b0;
    end else begin
      hold_ok_reg <= hold_ok_now;
    end
  end

  // Edges since the arbiter grant went low; a lost grant clears it.
  assign grant_cnt_next = en_grant ? 2'd0 :
    ((grant_cnt_reg == `BCC_GRANT_EDGES) ? grant_cnt_reg :
     grant_cnt_reg + 2'd1);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      grant_cnt_reg <= 2'd0;
    end else begin
      grant_cnt_reg <= grant_cnt_next; // RULE25
    end
  end

  // Command delay per mode: none in fast mode.
  always_comb begin
    if (!sysbus) begin
      need = 2'd0;
    end else if (is_write(cycle_reg)) begin
      need = `BCC_WR_CMD_DELAY; // RULE15
    end else begin
      need = `BCC_RD_CMD_DELAY; // RULE15
    end
  end

  // In system-bus mode the commands wait for three edges of grant;
  // in fast mode the enable gates them without floating them.
  assign cmd_en = sysbus ? (grant_cnt_next == `BCC_GRANT_EDGES) : // RULE23
                  en_grant; // RULE26
  // A high (lost) grant releases data enable at once.
  assign drv_en = sysbus ? !en_grant : en_grant; // RULE25 RULE26

  // One command line per cycle type; the others stay inactive.
  always_comb begin
    cmd_n_next = `BCC_RST_CMD_N;
    if (in_cmd_next && sel_reg && hold_ok_now && (cnt_next >= need) &&
        cmd_en) begin
      case (cycle_reg)
        BCC_CYC_IRQ_ACK: cmd_n_next[`BCC_CMD_IRQ_ACK] = 1'b0; // RULE9
        BCC_CYC_IO_RD: cmd_n_next[`BCC_CMD_IO_RD] = 1'b0;
        BCC_CYC_MEM_RD: cmd_n_next[`BCC_CMD_MEM_RD] = 1'b0;
        BCC_CYC_IO_WR: cmd_n_next[`BCC_CMD_IO_WR] = 1'b0; // RULE10
        BCC_CYC_MEM_WR: cmd_n_next[`BCC_CMD_MEM_WR] = 1'b0;
        default: cmd_n_next = `BCC_RST_CMD_N; // RULE11
      endcase
    end
  end

  // Command lines and their drive enable.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_n_reg <= `BCC_RST_CMD_N; // RULE28
      cmd_oe_reg <= `BCC_RST_CMD_OE;
    end else begin
      cmd_n_reg <= cmd_n_next; // RULE13
      cmd_oe_reg <= !sysbus || !en_grant; // RULE23
    end
  end

  // Address strobe covers the status state of any real cycle; the
  // cascade strobe stays one clock longer on acknowledge cycles.
  assign ale_next = starting && (dec_cycle != BCC_CYC_HALT); // RULE18
  assign mce_next = (starting && (dec_cycle == BCC_CYC_IRQ_ACK)) ||
                    ((state_reg == BCC_STAT) &&
                     (cycle_reg == BCC_CYC_IRQ_ACK)); // RULE19

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ale_reg <= `BCC_RST_ALE;
      mce_reg <= `BCC_RST_MCE;
    end else begin
      ale_reg <= ale_next;
      mce_reg <= mce_next;
    end
  end

  // Direction wanted: low from the status state of a selected read.
  assign want_read_dir =
    (starting && bus_sel && is_read(dec_cycle)) ||
    (in_cmd_next && sel_reg && is_read(cycle_reg)); // RULE8

  // Data enable wanted: reads from the command state; fast writes
  // from the status state, system-bus writes one clock later.
  always_comb begin
    want_den = 1'b0;
    if (starting && is_write(dec_cycle) && bus_sel && !sysbus) begin
      want_den = drv_en; // RULE14
    end else if (in_cmd_next && sel_reg &&
                 (is_read(cycle_reg) || is_write(cycle_reg))) begin
      want_den = drv_en; // RULE15 RULE17
    end
  end

  // The direction only moves while data enable is off, and data
  // enable only rises once the direction already matches, so the
  // transceivers never fight the bus on a turn-around.
  assign dir_next = den_reg ? dir_reg : !want_read_dir; // RULE12
  assign den_next = want_den && (dir_reg == !want_read_dir); // RULE12

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      den_reg <= `BCC_RST_DEN; // RULE28
      dir_reg <= `BCC_RST_DIR;
    end else begin
      den_reg <= den_next;
      dir_reg <= dir_next;
    end
  end

  // Every output comes straight from its flip-flop.
  assign irq_ack_cmd_n_o = cmd_n_reg[`BCC_CMD_IRQ_ACK];
  assign io_read_cmd_n_o = cmd_n_reg[`BCC_CMD_IO_RD];
  assign io_write_cmd_n_o = cmd_n_reg[`BCC_CMD_IO_WR];
  assign mem_read_cmd_n_o = cmd_n_reg[`BCC_CMD_MEM_RD];
  assign mem_write_cmd_n_o = cmd_n_reg[`BCC_CMD_MEM_WR];
  assign cmd_oe_o = cmd_oe_reg;
  assign addr_latch_strobe_o = ale_reg;
  assign cascade_enable_strobe_o = mce_reg;
  assign transceiver_enable_o = den_reg;
  assign transfer_direction_o = dir_reg;

endmodule

// ---- bcc_cycle_ctrl_sva.sv ----
// Checker for the output relations of the bus cycle controller.
`timescale 1ns/1ps

module bcc_cycle_ctrl_sva (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sysbus_timing_strap_i,
  input wire logic irq_ack_cmd_n_o,
  input wire logic io_read_cmd_n_o,
  input wire logic io_write_cmd_n_o,
  input wire logic mem_read_cmd_n_o,
  input wire logic mem_write_cmd_n_o,
  input wire logic cmd_oe_o,
  input wire logic addr_latch_strobe_o,
  input wire logic cascade_enable_strobe_o,
  input wire logic transceiver_enable_o,
  input wire logic transfer_direction_o
);
  // All five commands gathered, active low.
  wire logic [4:0] cmd_n = {mem_write_cmd_n_o, mem_read_cmd_n_o,
    io_write_cmd_n_o, io_read_cmd_n_o, irq_ack_cmd_n_o};
  // A read-type or a write-type command is active.
  wire logic rd_on = !irq_ack_cmd_n_o || !io_read_cmd_n_o ||
    !mem_read_cmd_n_o;
  wire logic wr_on = !io_write_cmd_n_o || !mem_write_cmd_n_o;

  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  ale_pulse_a: assert property (
    $rose(addr_latch_strobe_o) |=> !addr_latch_strobe_o)
    else $error("address strobe longer than one clock");
  cascade_len_a: assert property (
    $rose(cascade_enable_strobe_o) |-> addr_latch_strobe_o ##1
    (cascade_enable_strobe_o && !addr_latch_strobe_o) ##1
    !cascade_enable_strobe_o)
    else $error("cascade strobe not one clock past address strobe");
  dir_safe_a: assert property (
    !$stable(transfer_direction_o) |->
    !transceiver_enable_o && !$past(transceiver_enable_o))
    else $error("direction changed with transceivers enabled");
  cmd_onehot_a: assert property (
    $countones(~cmd_n) <= 1)
    else $error("more than one command active");
  ale_no_cmd_a: assert property (
    addr_latch_strobe_o |-> &cmd_n)
    else $error("command active during address strobe");
  cmd_has_en_a: assert property (
    cmd_oe_o && !(&cmd_n) |-> transceiver_enable_o)
    else $error("command active without transceiver enable");
  rd_dir_a: assert property (
    rd_on |-> !transfer_direction_o)
    else $error("read command with write direction");
  wr_dir_a: assert property (
    wr_on |-> transfer_direction_o)
    else $error("write command with read direction");
  sys_en_gap_a: assert property (
    sysbus_timing_strap_i && addr_latch_strobe_o |-> !transceiver_enable_o)
    else $error("transceiver enable held across shared-bus cycles");
  sys_cmd_late_a: assert property (
    sysbus_timing_strap_i && $fell(&cmd_n) |-> !$past(addr_latch_strobe_o))
    else $error("shared-bus command not delayed");
endmodule

bind bcc_cycle_ctrl bcc_cycle_ctrl_sva i_bcc_cycle_ctrl_sva (
  .clk_i, .sys_rst_i, .sysbus_timing_strap_i, .irq_ack_cmd_n_o,
  .io_read_cmd_n_o, .io_write_cmd_n_o, .mem_read_cmd_n_o,
  .mem_write_cmd_n_o, .cmd_oe_o, .addr_latch_strobe_o,
  .cascade_enable_strobe_o, .transceiver_enable_o,
  .transfer_direction_o);

// ---- bcc_cpu_model.sv ----
// Behavioural bus master and ready source facing the cycle controller.
`timescale 1ns/1ps

module bcc_cpu_model (
  input wire logic clk_i,
  output logic cycle_status_hi_n_o,
  output logic cycle_status_lo_n_o,
  output logic mem_io_sel_o,
  output logic command_hold_off_o,
  output logic ready_n_o
);
  // Status rests high as its pull-ups hold it; ready rests inactive.
  initial begin
    cycle_status_hi_n_o = 1'b1;
    cycle_status_lo_n_o = 1'b1;
    mem_io_sel_o = 1'b0;
    command_hold_off_o = 1'b0;
    ready_n_o = 1'b1;
  end

  // One cycle of type c with w wait states and h clocks of hold-off.
  // Edge k = 0 lies two clocks before the controller sees the status.
  task automatic issue(input logic [2:0] c, input int w, input int h);
    int k;
    for (k = 0; k <= 4 + 2 * w; k++) begin
      @(posedge clk_i);
      if (k == 0) begin
        // Status goes out only in phase one of the master clock.
        {mem_io_sel_o, cycle_status_hi_n_o, cycle_status_lo_n_o} <= c;
        command_hold_off_o <= (h > 0);
      end
      if (k == 2) begin
        // Select is inverted, not held, once the address has latched.
        mem_io_sel_o <= ~c[2];
        cycle_status_hi_n_o <= 1'b1;
        cycle_status_lo_n_o <= 1'b1;
      end
      // Hold-off drops after h clocks, or after ready at the latest.
      if (h > 0 && (k == 1 + h || k == 4 + 2 * w)) begin
        command_hold_off_o <= 1'b0;
      end
      // Ready is low for one clock only, so a following cycle that
      // starts at once is never ended early by a stale ready.
      if (k >= 3 + 2 * w) begin
        ready_n_o <= (k != 3 + 2 * w);
      end
    end
  endtask
endmodule

// ---- tb_cpu_bus_cycle_controller.sv ----
// Self-checking bench for the bus cycle controller.
`timescale 1ns/1ps

module tb_cpu_bus_cycle_controller
  import bcc_pkg::*;
;
  // Clock, reset, strap, bus select and enable or grant.
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic strap = 1'b0;
  logic sel = 1'b1;
  logic en_g = 1'b1;
  // Pins from the bus master model.
  logic st_hi, st_lo, mio, hold, rdy_n;
  // Controller outputs.
  logic [4:0] cmd_n;
  logic oe, ale, csc, xen, dir;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h08651c44;
  // Every decoded cycle type that starts a cycle.
  bcc_cycle_e ctab [6] = '{BCC_CYC_IRQ_ACK, BCC_CYC_IO_RD,
    BCC_CYC_IO_WR, BCC_CYC_HALT, BCC_CYC_MEM_RD, BCC_CYC_MEM_WR};

  // A half period of 2.5 ns gives 200 MHz.
  always #2.5 clk_i = ~clk_i;

  bcc_cycle_ctrl i_bcc_cycle_ctrl (
    .clk_i, .sys_rst_i, .cycle_status_hi_n_i(st_hi),
    .cycle_status_lo_n_i(st_lo), .mem_io_sel_i(mio),
    .sysbus_timing_strap_i(strap), .bus_select_latched_i(sel),
    .command_hold_off_i(hold), .enable_or_grant_i(en_g),
    .ready_n_i(rdy_n), .irq_ack_cmd_n_o(cmd_n[0]),
    .io_read_cmd_n_o(cmd_n[1]), .io_write_cmd_n_o(cmd_n[2]),
    .mem_read_cmd_n_o(cmd_n[3]), .mem_write_cmd_n_o(cmd_n[4]),
    .cmd_oe_o(oe), .addr_latch_strobe_o(ale),
    .cascade_enable_strobe_o(csc), .transceiver_enable_o(xen),
    .transfer_direction_o(dir));

  bcc_cpu_model i_bcc_cpu_model (
    .clk_i, .cycle_status_hi_n_o(st_hi), .cycle_status_lo_n_o(st_lo),
    .mem_io_sel_o(mio), .command_hold_off_o(hold), .ready_n_o(rdy_n));

  // Xorshift source; fixed seed so every run is the same.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Counts a comparison and reports a mismatch at once.
  task automatic cmp(input string what, input logic [9:0] seen,
    input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Reference model of one cycle, compared at every clock from the
  // address strobe on; nb marks a cycle followed at once by another.
  task automatic chk(input logic [2:0] c, input int w, input int h,
    input bit nb);
    int t, e, d, cs;
    bit rd, wr, go, xd, xr;
    logic [4:0] xc;
    rd = c == 3'h0 || c == 3'h1 || c == 3'h5;
    wr = c == 3'h2 || c == 3'h6;
    e = 3 + 2 * w;
    // Shared-bus timing adds one clock to reads and two to writes.
    d = strap ? (rd ? 1 : 2) : 0;
    cs = 2 + (h > d ? h : d);
    go = (rd || wr) && sel && (en_g ^ strap);
    repeat (3) @(posedge clk_i);
    for (t = 1; t <= e + (nb ? 0 : 1); t++) begin
      @(posedge clk_i);
      #1;
      xc = 5'h1f;
      // The last command clock is the one closed by the ready edge.
      if (go && t >= cs && t <= e) xc[c[2] ? c - 3'h2 : c] = 1'b0;
      xd = go && t <= e && t >= ((wr && !strap) ? 1 : 2);
      // Read direction lingers one clock once the transceivers were on.
      xr = rd && sel && (t <= e || (t == e + 1 && go));
      // Fast back-to-back writes keep the transceivers on.
      xd = xd || (nb && wr && go && !strap && t == e);
      if (!(strap && en_g)) cmp("command", cmd_n, xc);
      cmp("drive", oe, !(strap && en_g));
      cmp("address strobe", ale, (rd || wr) && t == 1);
      cmp("cascade", csc, c == 3'h0 && t <= 2);
      cmp("data enable", xen, xd);
      cmp("direction", dir, !xr);
    end
  endtask

  // Master and model run side by side over one cycle.
  task automatic cyc(input logic [2:0] c, input int w, input int h,
    input bit nb);
    fork
      i_bcc_cpu_model.issue(c, w, h);
      chk(c, w, h, nb);
    join
  endtask

  // Second status follows the first cycle's ready with no idle state.
  task automatic b2b(input logic [2:0] a, input logic [2:0] b);
    @(posedge clk_i);
    sel <= 1'b1;
    en_g <= ~strap;
    repeat (8) @(posedge clk_i);
    fork
      cyc(a, 1, 0, 1'b1);
      begin
        repeat (5) @(posedge clk_i);
        cyc(b, 2, 0, 1'b0);
      end
    join
  endtask

  // Fast timing first, then shared-bus timing after a second reset.
  initial begin
    int m, i, w, h;
    logic [31:0] r;
    for (m = 0; m < 2; m++) begin
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      strap <= m[0];
      repeat (12) @(posedge clk_i);
      #1;
      cmp("reset", {cmd_n, oe, ale, csc, xen, dir}, 10'h3f1);
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      cmp("release", {cmd_n, oe, ale, csc, xen, dir}, 10'h3f1);
      for (i = 0; i < 24; i++) begin
        r = rnd();
        // Shared-bus timing always gets a wait state.
        w = r[4:3] + m;
        h = (r[6:5] == 2'h0) ? 9 : (m ? 0 : r[8:7] % (2 * w + 1));
        @(posedge clk_i);
        sel <= r[11:9] != 3'h0;
        en_g <= (r[14:12] != 3'h0) ^ m[0];
        repeat (8) @(posedge clk_i);
        cyc(ctab[r[2:0] % 3'h6], w, h, 1'b0);
      end
      b2b(BCC_CYC_MEM_RD, BCC_CYC_IRQ_ACK);
      b2b(BCC_CYC_IO_WR, BCC_CYC_MEM_WR);
    end
    end_of_test();
  end
endmodule
